// File: rtl/iptc_pkg.sv
package iptc_pkg;
  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PROT = 8'h09; // i2c_protect_filter_cfg
  localparam logic [7:0] ADDR_OTIM = 8'h0A; // i2c_output_timing_cfg
  localparam logic [7:0] ADDR_HIGH = 8'h0B; // i2c_master_high_period
  localparam logic [7:0] ADDR_LOW = 8'h0C; // i2c_master_low_period
  localparam logic [7:0] RST_PROT = 8'h1E;
  localparam logic [7:0] RST_OTIM = 8'h10;
  localparam logic [7:0] RST_HIGH = 8'h7F;
  localparam logic [7:0] RST_LOW = 8'h7F;
  // field positions
  localparam int BIT_WBLK = 7;
  localparam int HOLD_LSB = 4;
  localparam int HOLD_W = 3;
  localparam int FILT_LSB = 0;
  localparam int FILT_W = 4;
  localparam int SETUP_LSB = 4;
  localparam int SETUP_W = 4;
  localparam int ODLY_LSB = 2;
  localparam int ODLY_W = 2;
  localparam int BIT_FAST = 1;
  localparam int BIT_WDDIS = 0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int FILT_UNIT_NS = 5;
  localparam int HOLD_UNIT_NS = 50;
  localparam int HOLD_CYC = HOLD_UNIT_NS / CLK_NS;
  localparam int HOLD_MAX_CYC = ((1 << HOLD_W) - 1) * HOLD_CYC;
  localparam int ODLY_BASE_NS = 240;
  localparam int ODLY_STEP_NS = 40;
  localparam int ODLY_BASE_CYC = ODLY_BASE_NS / CLK_NS;
  localparam int ODLY_STEP_CYC = ODLY_STEP_NS / CLK_NS;
  localparam int SETUP_BASE_NS = 80;
  localparam int SETUP_STEP_NS = 640;
  localparam int SETUP_BASE_CYC = (SETUP_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_STEP_CYC = (SETUP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_EXTRA = 5;
  localparam int OSC_KHZ = 26250;
  localparam int CLK_KHZ = 100000;
  localparam int ACC_GCD = 1250;
  localparam logic [6:0] ACC_ADD = 7'(OSC_KHZ / ACC_GCD);
  localparam logic [6:0] ACC_MOD = 7'(CLK_KHZ / ACC_GCD);
  localparam int WD_SLOW_NS = 1000000000;
  localparam int WD_FAST_NS = 50000;
  localparam logic [3:0] CLR_PULSES = 4'h9;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic remote;
    logic bridge;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iptc_req_s;
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} iptc_eng_e;
endpackage : iptc_pkg

// File: rtl/iptc_port_timing.sv
// Function
// - block remote writes to local registers when the write-block bit is set
// - bridged accesses to local slaves pass regardless of the write-block bit
// - delay the SDA input against SCL by hold field times 50 ns
// - reject SCL and SDA glitches up to filter field times 5 ns
// - remote ACK setup before SCL rise is 80 ns plus 640 ns per count
// - SDA output follows SCL fall by 240 ns plus 40 ns per step
// - bus watchdog expires after 1 s, or 50 us when fast
// - bus watchdog watches for a bad ending; disable bit stops it
// - SDA high and idle for a watchdog period means the bus is free
// - SDA low and idle until expiry starts nine SCL clear pulses
// - master SCL high lasts high field plus 5 oscillator periods
// - master SCL low lasts low field plus 5 oscillator periods
// - slave uses low count as SDA setup before releasing stretched SCL
// - SCL high and low counts run on the 26.25 MHz oscillator tick
`timescale 1ns/1ps
module iptc_port_timing #(
  parameter int WD_SLOW_CYC = iptc_pkg::WD_SLOW_NS / iptc_pkg::CLK_NS,
  parameter int WD_FAST_CYC = iptc_pkg::WD_FAST_NS / iptc_pkg::CLK_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input iptc_pkg::iptc_req_s req,
  input wire logic mst_run,
  input wire logic sda_en,
  input wire logic sda_bit,
  input wire logic slv_hold,
  input wire logic slv_ack,
  input wire logic rmt_active,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic [7:0] rdata,
  output logic rd_valid,
  output logic wr_reject,
  output logic bridge_fwd,
  output logic bus_busy,
  output logic bus_free,
  output logic bus_clearing
);
  import iptc_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] prot_reg, prot_next, otim_reg, otim_next;
  logic [7:0] high_reg, high_next, low_reg, low_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rdv_reg, rdv_next, rej_reg, rej_next, fwd_reg, fwd_next;

  // bridged traffic is decided first so the block bit never touches it
  always_comb begin
    prot_next = prot_reg;
    otim_next = otim_reg;
    high_next = high_reg;
    low_next = low_reg;
    rdata_next = rdata_reg;
    rdv_next = 1'b0;
    rej_next = 1'b0;
    fwd_next = 1'b0;
    if (req.bridge) begin
      fwd_next = req.wr | req.rd;
    end else if (req.wr) begin
      if (req.remote && prot_reg[BIT_WBLK]) begin
        rej_next = 1'b1;
      end else begin
        case (req.addr)
          ADDR_PROT: prot_next = req.wdata;
          ADDR_OTIM: otim_next = req.wdata;
          ADDR_HIGH: high_next = req.wdata;
          ADDR_LOW: low_next = req.wdata;
          default: ;
        endcase
      end
    end else if (req.rd) begin
      rdv_next = 1'b1;
      case (req.addr)
        ADDR_PROT: rdata_next = prot_reg;
        ADDR_OTIM: rdata_next = otim_reg;
        ADDR_HIGH: rdata_next = high_reg;
        ADDR_LOW: rdata_next = low_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_reg <= RST_PROT;
      otim_reg <= RST_OTIM;
      high_reg <= RST_HIGH;
      low_reg <= RST_LOW;
      rdata_reg <= 8'h00;
      rdv_reg <= 1'b0;
      rej_reg <= 1'b0;
      fwd_reg <= 1'b0;
    end else begin
      prot_reg <= prot_next;
      otim_reg <= otim_next;
      high_reg <= high_next;
      low_reg <= low_next;
      rdata_reg <= rdata_next;
      rdv_reg <= rdv_next;
      rej_reg <= rej_next;
      fwd_reg <= fwd_next;
    end
  end

  // ---------------------------------------------------------------
  // oscillator tick: 21 of every 80 clocks, i.e. 26.25 MHz on average
  // ---------------------------------------------------------------
  logic [6:0] acc_reg, acc_next;
  logic tick;
  logic [7:0] acc_sum;

  always_comb begin
    acc_sum = {1'b0, acc_reg} + {1'b0, ACC_ADD};
    tick = (acc_sum >= {1'b0, ACC_MOD});
    acc_next = tick ? 7'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[6:0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) acc_reg <= 7'h00;
    else acc_reg <= acc_next;
  end

  // ---------------------------------------------------------------
  // glitch filters, index 0 is SCL and 1 is SDA
  // ---------------------------------------------------------------
  logic [1:0] raw, flt;
  logic [3:0] fcyc;
  logic [6:0] fsum;
  assign raw = {sda_i, scl_i};
  // the depth is in 5 ns units, so each 10 ns sample covers two of them
  // seven bits hold the largest depth sum, so the division never sees a wrapped value
  assign fsum = 7'(prot_reg[FILT_LSB +: FILT_W] * FILT_UNIT_NS + CLK_NS - 1);
  assign fcyc = 4'(fsum / 7'(CLK_NS));

  for (genvar i = 0; i < 2; i++) begin : g_flt
    logic f_reg, f_next;
    logic [3:0] c_reg, c_next;
    always_comb begin
      f_next = f_reg;
      c_next = 4'h0;
      if (raw[i] != f_reg) begin
        if (c_reg >= fcyc) f_next = raw[i];
        else c_next = c_reg + 4'h1;
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        f_reg <= 1'b1;
        c_reg <= 4'h0;
      end else begin
        f_reg <= f_next;
        c_reg <= c_next;
      end
    end
    assign flt[i] = f_reg;
  end

  // ---------------------------------------------------------------
  // sda hold line and edge history
  // ---------------------------------------------------------------
  logic [HOLD_MAX_CYC-1:0] sh_reg, sh_next;
  logic [5:0] hcyc;
  logic scl_f, sda_h, scl_q_reg, sda_q_reg, hold_q_reg;
  logic scl_fall, act, start, stop;

  assign scl_f = flt[0];
  assign hcyc = 6'(prot_reg[HOLD_LSB +: HOLD_W] * HOLD_CYC);
  assign sh_next = {sh_reg[HOLD_MAX_CYC-2:0], flt[1]};
  assign sda_h = (hcyc == 6'h00) ? flt[1] : sh_reg[hcyc - 6'h01];
  assign scl_fall = scl_q_reg & ~scl_f;
  assign act = (scl_q_reg ^ scl_f) | (sda_q_reg ^ sda_h);
  assign start = scl_f & scl_q_reg & sda_q_reg & ~sda_h;
  assign stop = scl_f & scl_q_reg & ~sda_q_reg & sda_h;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_reg <= '1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      hold_q_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_h;
      hold_q_reg <= slv_hold;
    end
  end

  // ---------------------------------------------------------------
  // scl engine: master clocking and nine-pulse bus clear
  // ---------------------------------------------------------------
  iptc_eng_e eng_reg, eng_next;
  logic [8:0] ecnt_reg, ecnt_next, lo_lim, hi_lim;
  logic [3:0] np_reg, np_next;
  logic clr_reg, clr_next, clr_done, clr_go;

  assign lo_lim = 9'(low_reg) + 9'(OSC_EXTRA);
  assign hi_lim = 9'(high_reg) + 9'(OSC_EXTRA);

  always_comb begin
    eng_next = eng_reg;
    ecnt_next = ecnt_reg;
    np_next = np_reg;
    clr_next = clr_reg;
    clr_done = 1'b0;
    case (eng_reg)
      E_IDLE: begin
        ecnt_next = 9'h000;
        if (clr_go) begin
          clr_next = 1'b1;
          np_next = 4'h0;
        end
        // leave idle on a tick so the first low phase is never a tick short
        if ((clr_go || clr_reg || mst_run) && tick) begin
          eng_next = E_LOW;
        end
      end
      E_LOW: begin
        if (tick) begin
          if (ecnt_reg >= lo_lim - 9'h001) begin
            ecnt_next = 9'h000;
            eng_next = E_HIGH;
          end else begin
            ecnt_next = ecnt_reg + 9'h001;
          end
        end
      end
      E_HIGH: begin
        // a slave stretching SCL pauses the high count
        if (tick && scl_f) begin
          if (ecnt_reg >= hi_lim - 9'h001) begin
            ecnt_next = 9'h000;
            if (clr_reg) begin
              np_next = np_reg + 4'h1;
              if (np_reg == CLR_PULSES - 4'h1) begin
                clr_next = 1'b0;
                clr_done = 1'b1;
                eng_next = E_IDLE;
              end else begin
                eng_next = E_LOW;
              end
            end else begin
              eng_next = mst_run ? E_LOW : E_IDLE;
            end
          end else begin
            ecnt_next = ecnt_reg + 9'h001;
          end
        end
      end
      default: eng_next = E_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eng_reg <= E_IDLE;
      ecnt_reg <= 9'h000;
      np_reg <= 4'h0;
      clr_reg <= 1'b0;
    end else begin
      eng_reg <= eng_next;
      ecnt_reg <= ecnt_next;
      np_reg <= np_next;
      clr_reg <= clr_next;
    end
  end

  // ---------------------------------------------------------------
  // bus watchdog
  // ---------------------------------------------------------------
  logic [26:0] wd_reg, wd_next, wd_lim;
  logic busy_reg, busy_next, free_reg, free_next, expire;

  // counting only while busy keeps a healthy idle bus from tripping it
  assign wd_lim = otim_reg[BIT_FAST] ? 27'(WD_FAST_CYC) : 27'(WD_SLOW_CYC);
  assign expire = busy_reg & ~otim_reg[BIT_WDDIS] & (eng_reg == E_IDLE) & ~act
    & (wd_reg >= wd_lim - 27'h0000001);
  assign clr_go = expire & ~sda_h;

  always_comb begin
    wd_next = wd_reg + 27'h0000001;
    busy_next = busy_reg;
    free_next = 1'b0;
    if (start) busy_next = 1'b1;
    if (stop || clr_done) busy_next = 1'b0;
    if (act || !busy_reg || otim_reg[BIT_WDDIS] || eng_reg != E_IDLE) begin
      wd_next = 27'h0000000;
    end else if (expire) begin
      wd_next = 27'h0000000;
      if (sda_h) begin
        free_next = 1'b1;
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_reg <= 27'h0000000;
      busy_reg <= 1'b0;
      free_reg <= 1'b0;
    end else begin
      wd_reg <= wd_next;
      busy_reg <= busy_next;
      free_reg <= free_next;
    end
  end

  // ---------------------------------------------------------------
  // sda output timing and slave stretch
  // ---------------------------------------------------------------
  logic [5:0] od_reg, od_next, od_lim;
  logic od_run_reg, od_run_next, sdoe_reg, sdoe_next;
  logic str_reg, str_next, scoe_reg, scoe_next, ack_rmt, s_en;
  logic [9:0] sc_reg, sc_next, s_lim;

  assign od_lim = 6'(ODLY_BASE_CYC) + 6'(otim_reg[ODLY_LSB +: ODLY_W] * ODLY_STEP_CYC);
  assign ack_rmt = slv_ack & rmt_active;
  assign s_lim = ack_rmt
    ? 10'(SETUP_BASE_CYC) + 10'(otim_reg[SETUP_LSB +: SETUP_W] * SETUP_STEP_CYC)
    : 10'(lo_lim);
  // the ack setup counts in system clocks, the plain setup in oscillator ticks
  assign s_en = ack_rmt | tick;

  always_comb begin
    od_next = od_reg;
    od_run_next = od_run_reg;
    sdoe_next = sdoe_reg;
    str_next = str_reg;
    sc_next = 10'h000;
    if (scl_fall) begin
      od_run_next = 1'b1;
      od_next = 6'h00;
    end else if (od_run_reg) begin
      if (od_reg >= od_lim - 6'h01) begin
        od_run_next = 1'b0;
        sdoe_next = sda_en & ~sda_bit;
      end else begin
        od_next = od_reg + 6'h01;
      end
    end
    if (!str_reg) begin
      str_next = slv_hold & ~scl_f;
    end else if (!slv_hold) begin
      if (hold_q_reg) sdoe_next = sda_en & ~sda_bit;
      sc_next = s_en ? sc_reg + 10'h001 : sc_reg;
      if (sc_reg >= s_lim) str_next = 1'b0;
    end
    // a bus clear must never fight the stuck slave on SDA
    if (clr_reg) sdoe_next = 1'b0;
    scoe_next = (eng_next == E_LOW) | str_next;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      od_reg <= 6'h00;
      od_run_reg <= 1'b0;
      sdoe_reg <= 1'b0;
      str_reg <= 1'b0;
      sc_reg <= 10'h000;
      scoe_reg <= 1'b0;
    end else begin
      od_reg <= od_next;
      od_run_reg <= od_run_next;
      sdoe_reg <= sdoe_next;
      str_reg <= str_next;
      sc_reg <= sc_next;
      scoe_reg <= scoe_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs; open-drain pins only ever drive low
  // ---------------------------------------------------------------
  logic lvl_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lvl_reg <= 1'b0;
    else lvl_reg <= 1'b0;
  end

  assign scl_o = lvl_reg;
  assign sda_o = lvl_reg;
  assign scl_oe = scoe_reg;
  assign sda_oe = sdoe_reg;
  assign rdata = rdata_reg;
  assign rd_valid = rdv_reg;
  assign wr_reject = rej_reg;
  assign bridge_fwd = fwd_reg;
  assign bus_busy = busy_reg;
  assign bus_free = free_reg;
  assign bus_clearing = clr_reg;
endmodule : iptc_port_timing

// File: test/iptc_props.sv
`timescale 1ns/1ps
module iptc_props #(
  parameter int WD_SLOW_CYC = 200,
  parameter int WD_FAST_CYC = 50
) (
  input wire logic clk,
  input wire logic resetn,
  input iptc_pkg::iptc_req_s req,
  input wire logic mst_run,
  input wire logic slv_hold,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic wr_reject,
  input wire logic bridge_fwd,
  input wire logic bus_busy,
  input wire logic bus_free,
  input wire logic bus_clearing
);
  import iptc_pkg::*;
  // ----------
  // shadow registers and bus counters
  // ----------
  logic [7:0] prot_reg, otim_reg, high_reg, low_reg;
  logic [10:0] on_cnt, off_cnt;
  logic [3:0] clr_cnt;
  logic scl_d, sda_d, wr_ok;
  int idle_cnt;
  assign wr_ok = req.wr && !req.bridge && !(req.remote && prot_reg[BIT_WBLK]);
  function automatic int cyc(input logic [7:0] f);
    return (int'(f) + OSC_EXTRA) * int'(ACC_MOD) / int'(ACC_ADD);
  endfunction : cyc
  // idle counts raw pins, which move before the filtered copy inside
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_reg <= RST_PROT;
      otim_reg <= RST_OTIM;
      high_reg <= RST_HIGH;
      low_reg <= RST_LOW;
      on_cnt <= '0;
      off_cnt <= '0;
      clr_cnt <= '0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      idle_cnt <= 0;
    end else begin
      if (wr_ok && req.addr == ADDR_PROT) prot_reg <= req.wdata;
      if (wr_ok && req.addr == ADDR_OTIM) otim_reg <= req.wdata;
      if (wr_ok && req.addr == ADDR_HIGH) high_reg <= req.wdata;
      if (wr_ok && req.addr == ADDR_LOW) low_reg <= req.wdata;
      on_cnt <= scl_oe ? on_cnt + 11'h1 : '0;
      off_cnt <= scl_oe ? '0 : off_cnt + 11'(off_cnt != 11'h7FF); // saturates
      clr_cnt <= bus_clearing ? clr_cnt + 4'($rose(scl_oe)) : '0;
      scl_d <= scl_i;
      sda_d <= sda_i;
      idle_cnt <= (scl_i != scl_d || sda_i != sda_d) ? 0 : idle_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rej;
    wr_reject == $past(req.wr && req.remote && !req.bridge && prot_reg[BIT_WBLK]);
  endproperty
  a_rej: assert property (p_rej) else $error("write refusal wrong");
  property p_brg;
    bridge_fwd == $past((req.wr || req.rd) && req.bridge);
  endproperty
  a_brg: assert property (p_brg) else $error("bridge pass wrong");
  property p_low;
    $fell(scl_oe) && mst_run && !slv_hold && !bus_clearing |->
      on_cnt >= cyc(low_reg) - 2 && on_cnt <= cyc(low_reg) + 3;
  endproperty
  a_low: assert property (p_low) else $error("master low period wrong");
  property p_high;
    $rose(scl_oe) && mst_run && $past(mst_run) && !bus_clearing |-> off_cnt >= cyc(high_reg) - 2;
  endproperty
  a_high: assert property (p_high) else $error("master high period short");
  property p_clr9;
    $fell(bus_clearing) |-> clr_cnt == CLR_PULSES;
  endproperty
  a_clr9: assert property (p_clr9) else $error("clear pulse count wrong");
  property p_wd;
    bus_free || $rose(bus_clearing) |->
      idle_cnt >= (otim_reg[BIT_FAST] ? WD_FAST_CYC : WD_SLOW_CYC) - 1;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog expired early");
  property p_wddis;
    otim_reg[BIT_WDDIS] && $past(otim_reg[BIT_WDDIS]) |-> !bus_free && !$rose(bus_clearing);
  endproperty
  a_wddis: assert property (p_wddis) else $error("watchdog ran while off");
  property p_sdaclr;
    bus_clearing && $past(bus_clearing) |-> !sda_oe;
  endproperty
  a_sdaclr: assert property (p_sdaclr) else $error("sda driven in clear");
  property p_free;
    bus_free |-> $past(bus_busy) ##1 !bus_busy;
  endproperty
  a_free: assert property (p_free) else $error("free bus still busy");
  c_rej: cover property (wr_reject);
  c_free: cover property (bus_free);
  c_clr: cover property ($rose(bus_clearing));
  c_mst: cover property ($fell(scl_oe) && mst_run);
endmodule : iptc_props
bind iptc_port_timing iptc_props #(.WD_SLOW_CYC(WD_SLOW_CYC), .WD_FAST_CYC(WD_FAST_CYC))
  u_props (.clk(clk), .resetn(resetn), .req(req), .mst_run(mst_run), .slv_hold(slv_hold),
  .scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe), .sda_oe(sda_oe), .wr_reject(wr_reject),
  .bridge_fwd(bridge_fwd), .bus_busy(bus_busy), .bus_free(bus_free),
  .bus_clearing(bus_clearing));

// File: test/iptc_bus_model.sv
`timescale 1ns/1ps
module iptc_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic scl_pull,
  input wire logic sda_pull,
  output logic scl_i,
  output logic sda_i
);
  // open-drain lines with pull-ups: any party pulling low wins
  assign scl_i = !(scl_oe || scl_pull);
  assign sda_i = !(sda_oe || sda_pull);
endmodule : iptc_bus_model

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import iptc_pkg::*;
  // ----------
  // short watchdog limits keep the run brief
  // ----------
  localparam int SLOW = 200;
  localparam int FAST = 50;
  logic clk = 1'b0, resetn = 1'b0, mst_run = 1'b0, sda_en = 1'b0, sda_bit = 1'b1;
  logic slv_hold = 1'b0, slv_ack = 1'b0, rmt_active = 1'b0, scl_pull = 1'b0, sda_pull = 1'b0;
  logic scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe, rd_valid, wr_reject, bridge_fwd;
  logic bus_busy, bus_free, bus_clearing, pe;
  logic [7:0] rdata;
  logic [31:0] lfsr = 32'h42EBE69C;
  iptc_req_s req = '0;
  int bad_count = 0, compares = 0;
  int mdl [4];
  always #5 clk = ~clk;
  iptc_port_timing #(.WD_SLOW_CYC(SLOW), .WD_FAST_CYC(FAST)) dut (
    .clk(clk), .resetn(resetn), .req(req), .mst_run(mst_run), .sda_en(sda_en),
    .sda_bit(sda_bit), .slv_hold(slv_hold), .slv_ack(slv_ack), .rmt_active(rmt_active),
    .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
    .sda_oe(sda_oe), .rdata(rdata), .rd_valid(rd_valid), .wr_reject(wr_reject),
    .bridge_fwd(bridge_fwd), .bus_busy(bus_busy), .bus_free(bus_free),
    .bus_clearing(bus_clearing));
  iptc_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .scl_i(scl_i), .sda_i(sda_i));
  // ----------
  // helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic lim(input int n, input int max);
    if (n >= max) begin
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask : lim
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic int cyc(input int f);
    return (f + OSC_EXTRA) * 80 / 21;
  endfunction : cyc
  // one register access, judged against the model
  task automatic acc(input logic wr, input logic rm, input logic br, input logic [7:0] a,
      input logic [7:0] d);
    logic blk, hit;
    blk = wr && rm && !br && mdl[0][BIT_WBLK];
    hit = a >= ADDR_PROT && a <= ADDR_LOW;
    @(negedge clk);
    req = '{wr: wr, rd: !wr, remote: rm, bridge: br, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    check(wr_reject, blk, "reject");
    check(bridge_fwd, br, "bridge");
    if (wr && !br && !blk && hit) mdl[a - ADDR_PROT] = d;
    if (!wr && !br) check(rdata, hit ? mdl[a - ADDR_PROT] : 0, "rdata");
    check(rd_valid, !wr && !br, "read valid");
  endtask : acc
  // walk into a START, leave SDA low or high with SCL high, then time the watchdog
  task automatic hang(input logic low, input int max, output int n);
    sda_pull = 1'b1;
    repeat (20) @(negedge clk);
    scl_pull = 1'b1;
    repeat (20) @(negedge clk);
    sda_pull = low;
    repeat (20) @(negedge clk);
    scl_pull = 1'b0;
    for (n = 0; n < max && bus_free !== 1'b1 && bus_clearing !== 1'b1; n++) @(negedge clk);
  endtask : hang
  // ----------
  // main sequence
  // ----------
  initial begin
    int n, k;
    mdl = '{RST_PROT, RST_OTIM, RST_HIGH, RST_LOW};
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    for (int a = 8; a <= 13; a++) acc(1'b0, 1'b0, 1'b0, 8'(a), 8'h00);
    for (int i = 0; i < 10; i++) acc(i[0], 1'b0, 1'b0, 8'(9 + i / 2), rnd());
    check(scl_o | sda_o, 1'b0, "open drain");
    acc(1'b1, 1'b0, 1'b0, ADDR_PROT, 8'h80);
    acc(1'b1, 1'b1, 1'b0, ADDR_LOW, 8'h03);
    acc(1'b1, 1'b1, 1'b1, ADDR_LOW, 8'h55);
    acc(1'b0, 1'b1, 1'b1, ADDR_PROT, 8'h00);
    acc(1'b0, 1'b0, 1'b0, ADDR_LOW, 8'h00);
    acc(1'b1, 1'b0, 1'b0, ADDR_PROT, 8'h1E);
    acc(1'b1, 1'b1, 1'b0, ADDR_LOW, 8'h03);
    acc(1'b1, 1'b0, 1'b0, ADDR_HIGH, 8'h02);
    acc(1'b1, 1'b0, 1'b0, ADDR_OTIM, 8'h02);
    // a seven-sample dip is a glitch, a held low is a START
    sda_pull = 1'b1;
    repeat (7) @(negedge clk);
    sda_pull = 1'b0;
    repeat (20) @(negedge clk);
    check(bus_busy, 1'b0, "glitch");
    sda_pull = 1'b1;
    for (n = 0; n < 100 && bus_busy !== 1'b1; n++) @(negedge clk);
    check(n >= 7 + HOLD_CYC && n <= 12 + HOLD_CYC, 1'b1, "start");
    // hung slave keeps SDA low: expect nine clearing pulses
    hang(1'b1, FAST + 100, n);
    lim(n, FAST + 100);
    check(n >= FAST && n <= FAST + 15, 1'b1, "hung expiry");
    k = 0;
    pe = 1'b0;
    for (n = 0; n < 3000 && bus_clearing === 1'b1; n++) begin
      k += int'(scl_oe === 1'b1 && pe === 1'b0);
      pe = scl_oe;
      @(negedge clk);
    end
    lim(n, 3000);
    check(k, 9, "clear pulses");
    check(bus_busy, 1'b0, "busy after clear");
    sda_pull = 1'b0;
    repeat (20) @(negedge clk);
    hang(1'b0, FAST + 100, n);
    lim(n, FAST + 100);
    check(n >= FAST && n <= FAST + 15, 1'b1, "free expiry");
    @(negedge clk);
    check(bus_busy, 1'b0, "free");
    acc(1'b1, 1'b0, 1'b0, ADDR_OTIM, 8'h00);
    hang(1'b0, SLOW + 100, n);
    lim(n, SLOW + 100);
    check(n >= SLOW && n <= SLOW + 15, 1'b1, "slow expiry");
    acc(1'b1, 1'b0, 1'b0, ADDR_OTIM, 8'h01);
    hang(1'b0, 300, n);
    check(n, 300, "disabled");
    // output delay after each SCL fall, every delay code
    acc(1'b1, 1'b0, 1'b0, ADDR_PROT, 8'h00);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 1'b0, 1'b0, ADDR_OTIM, 8'(c * 4 + 1));
      sda_en = 1'b1;
      sda_bit = c[0];
      scl_pull = 1'b1;
      for (n = 0; n < 200 && sda_oe !== !c[0]; n++) @(negedge clk);
      lim(n, 200);
      check(n >= 24 + 4 * c && n <= 28 + 4 * c, 1'b1, "sda delay");
      sda_en = 1'b0;
      scl_pull = 1'b0;
      repeat (30) @(negedge clk);
    end
    // slave stretch: plain setup in ticks, remote ack setup in clocks
    acc(1'b1, 1'b0, 1'b0, ADDR_OTIM, 8'h11);
    for (int m = 0; m < 2; m++) begin
      slv_ack = m[0];
      rmt_active = m[0];
      scl_pull = 1'b1;
      repeat (10) @(negedge clk);
      slv_hold = 1'b1;
      repeat (10) @(negedge clk);
      scl_pull = 1'b0;
      repeat (10) @(negedge clk);
      sda_en = 1'b1;
      sda_bit = 1'b0;
      slv_hold = 1'b0;
      for (n = 0; n < 2000 && scl_oe === 1'b1; n++) @(negedge clk);
      lim(n, 2000);
      check(sda_oe, 1'b1, "setup data");
      k = m ? SETUP_BASE_CYC + SETUP_STEP_CYC : cyc(3);
      check(n >= k - 2 && n <= k + 3, 1'b1, "setup time");
      sda_en = 1'b0;
      repeat (60) @(negedge clk);
    end
    slv_ack = 1'b0;
    rmt_active = 1'b0;
    // master clocking with short periods
    repeat (300) @(negedge clk);
    mst_run = 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (n = 0; n < 2000 && scl_oe !== 1'b1; n++) @(negedge clk);
      lim(n, 2000);
      for (n = 0; n < 2000 && scl_oe === 1'b1; n++) @(negedge clk);
      lim(n, 2000);
      check(n >= cyc(3) - 2 && n <= cyc(3) + 3, 1'b1, "low period");
    end
    mst_run = 1'b0;
    give_verdict();
  end
endmodule : tb
